// [hdl/fcs_pkg.sv]
package fcs_pkg;

    localparam int CLK_NS = 4;
    localparam int SETTLE_NS = 100;
    localparam int VERIFY_US = 6;
    localparam int PULSE_MS = 10;
    localparam int RECOV_MS = 6;
    localparam int STROBE_NS = 60;
    localparam int ACCESS_NS = 120;

    function automatic int fcs_cycles(input int ns);
        fcs_cycles = (ns + CLK_NS - 1) / CLK_NS;
    endfunction : fcs_cycles

    localparam int SETTLE_CYC = fcs_cycles(SETTLE_NS);
    localparam int VERIFY_CYC = fcs_cycles(VERIFY_US * 1000);
    localparam int PULSE_CYC = fcs_cycles(PULSE_MS * 1000000);
    localparam int RECOV_CYC = fcs_cycles(RECOV_MS * 1000000);
    localparam int STROBE_CYC = fcs_cycles(STROBE_NS);
    localparam int ACCESS_CYC = fcs_cycles(ACCESS_NS);

    localparam int ADDR_W = 18;
    localparam int CNT_W = 22;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 18'h3ffff;
    localparam logic [ADDR_W-1:0] SIG_MFR_ADDR = 18'h00000;
    localparam logic [ADDR_W-1:0] SIG_DEV_ADDR = 18'h00001;

    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROG_ARM = 8'h40;
    localparam logic [7:0] CMD_PROG_CHECK = 8'hc0;
    localparam logic [7:0] CMD_ERASE_CHECK = 8'ha0;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    localparam logic [9:0] PROG_MAX_PULSES = 10'd25;
    localparam logic [9:0] ERASE_MAX_PULSES = 10'd1000;

    typedef enum logic [2:0] {
        FCS_OP_READ,
        FCS_OP_PROGRAM,
        FCS_OP_ERASE,
        FCS_OP_SIGNATURE,
        FCS_OP_RESET
    } fcs_op_type;

endpackage : fcs_pkg

// [hdl/fcs_bus_if.sv]
`timescale 1ns/100ps
interface fcs_bus_if;
    logic req;
    logic is_write;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;

    modport master (
        output req,
        output is_write,
        output addr,
        output wdata,
        input done,
        input rdata
    );

    modport slave (
        input req,
        input is_write,
        input addr,
        input wdata,
        output done,
        output rdata
    );
endinterface : fcs_bus_if

// [hdl/fcs_bus_cycle.sv]
`timescale 1ns/100ps
module fcs_bus_cycle
    import fcs_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    fcs_bus_if.slave bus,
    input wire logic [7:0] flash_dq_in,
    output logic [17:0] flash_addr_out,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out
);

    typedef enum logic [1:0] {
        B_IDLE,
        B_STROBE,
        B_HOLD
    } fcs_bus_state_type;

    fcs_bus_state_type state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic [17:0] addr_r, addr_nxt;
    logic [7:0] dq_r, dq_nxt;
    logic dq_oe_r, dq_oe_nxt;
    logic ce_n_r, ce_n_nxt;
    logic oe_n_r, oe_n_nxt;
    logic we_n_r, we_n_nxt;
    logic done_r, done_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] dq_meta_r;
    logic [7:0] dq_sync_r;

    // ----
    // Data pin synchroniser.
    // ----
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dq_meta_r <= 8'h00;
            dq_sync_r <= 8'h00;
        end else begin
            dq_meta_r <= flash_dq_in;
            dq_sync_r <= dq_meta_r;
        end
    end

    // ----
    // Strobe cycle sequencing.
    // ----
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        addr_nxt = addr_r;
        dq_nxt = dq_r;
        dq_oe_nxt = dq_oe_r;
        ce_n_nxt = ce_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (state_r)
            B_IDLE: begin
                if (bus.req && !done_r) begin
                    wr_nxt = bus.is_write;
                    addr_nxt = bus.addr;
                    dq_nxt = bus.wdata;
                    dq_oe_nxt = bus.is_write;
                    ce_n_nxt = 1'b0;
                    we_n_nxt = ~bus.is_write;
                    oe_n_nxt = bus.is_write;
                    cnt_nxt = bus.is_write ? 8'(STROBE_CYC - 1) : 8'(ACCESS_CYC - 1);
                    state_nxt = B_STROBE;
                end
            end
            B_STROBE: begin
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else if (wr_r) begin
                    we_n_nxt = 1'b1;
                    cnt_nxt = 8'(STROBE_CYC - 1);
                    state_nxt = B_HOLD;
                end else begin
                    rdata_nxt = dq_sync_r;
                    oe_n_nxt = 1'b1;
                    ce_n_nxt = 1'b1;
                    done_nxt = 1'b1;
                    state_nxt = B_IDLE;
                end
            end
            B_HOLD: begin
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    ce_n_nxt = 1'b1;
                    dq_oe_nxt = 1'b0;
                    done_nxt = 1'b1;
                    state_nxt = B_IDLE;
                end
            end
            default: begin
                state_nxt = B_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= B_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            addr_r <= 18'h00000;
            dq_r <= 8'h00;
            dq_oe_r <= 1'b0;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            dq_r <= dq_nxt;
            dq_oe_r <= dq_oe_nxt;
            ce_n_r <= ce_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign bus.done = done_r;
    assign bus.rdata = rdata_r;
    assign flash_addr_out = addr_r;
    assign flash_dq_out = dq_r;
    assign flash_dq_oe_out = dq_oe_r;
    assign flash_ce_n_out = ce_n_r;
    assign flash_oe_n_out = oe_n_r;
    assign flash_we_n_out = we_n_r;

endmodule : fcs_bus_cycle

// [hdl/fcs_host.sv]
// Operation
// - Wait verify delay after program check
// - Compare readback, retry up to 25 pulses
// - After pass, accept next address
// - Supply settles 100 ns before commands
// - Timed erase pulse, then erase check
// - Timed program pulse, abort on interrupt
// - No verify read during write recovery
// - Mask erased device with read command
// - Reset twice after program arm
// - Reset twice after signature, reset and failed erase
// - No reset after read or passed erase
// - Leave signature mode with reset command
`timescale 1ns/100ps
module fcs_host
    import fcs_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int RECOV_CYCLES = RECOV_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire fcs_op_type cmd_op_in,
    input wire logic [17:0] cmd_addr_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic abort_in,
    output logic busy_out,
    output logic done_out,
    output logic pass_out,
    output logic [15:0] result_out,
    output logic program_supply_out,
    input wire logic [7:0] flash_dq_in,
    output logic [17:0] flash_addr_out,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out
);

    localparam int WAIT_CYCLES = (RECOV_CYCLES > VERIFY_CYC) ? RECOV_CYCLES : VERIFY_CYC;

    typedef enum logic [4:0] {
        S_IDLE, S_SETTLE, S_P_ARM, S_P_DATA, S_P_PULSE, S_P_CHECK, S_RECOV, S_P_READ,
        S_E_SET, S_E_GO, S_E_PULSE, S_E_CHECK, S_E_READ, S_MASK,
        S_RST1, S_RST2, S_SIG_CMD, S_SIG0, S_SIG1, S_RD, S_FINISH
    } fcs_state_type;

    fcs_state_type state_r, state_nxt;
    fcs_op_type op_r, op_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [9:0] pulses_r, pulses_nxt;
    logic [17:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt;
    logic pass_r, pass_nxt;
    logic [15:0] result_r, result_nxt;
    logic supply_r, supply_nxt;
    logic done_r, done_nxt;
    logic busy_r, busy_nxt;
    logic bus_done;
    logic [7:0] bus_rdata;

    fcs_bus_if bus ();

    // ----
    // Bus request per state.
    // ----
    always_comb begin
        bus.req = 1'b1;
        bus.is_write = 1'b1;
        bus.addr = addr_r;
        bus.wdata = CMD_RESET;
        case (state_r)
            S_P_ARM: bus.wdata = CMD_PROG_ARM;
            S_P_DATA: bus.wdata = data_r;
            S_P_CHECK: bus.wdata = CMD_PROG_CHECK;
            S_P_READ, S_E_READ, S_RD: bus.is_write = 1'b0;
            S_E_SET, S_E_GO: bus.wdata = CMD_ERASE;
            S_E_CHECK: bus.wdata = CMD_ERASE_CHECK;
            S_MASK: bus.wdata = CMD_READ;
            S_RST1, S_RST2: bus.wdata = CMD_RESET;
            S_SIG_CMD: bus.wdata = CMD_SIGNATURE;
            S_SIG0: begin
                bus.is_write = 1'b0;
                bus.addr = SIG_MFR_ADDR;
            end
            S_SIG1: begin
                bus.is_write = 1'b0;
                bus.addr = SIG_DEV_ADDR;
            end
            default: bus.req = 1'b0;
        endcase
    end

    assign bus_done = bus.done;
    assign bus_rdata = bus.rdata;

    // ----
    // Sequencer.
    // ----
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        cnt_nxt = cnt_r;
        pulses_nxt = pulses_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        pass_nxt = pass_r;
        result_nxt = result_r;
        supply_nxt = supply_r;
        done_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (cmd_valid_in) begin
                    op_nxt = cmd_op_in;
                    addr_nxt = cmd_addr_in;
                    data_nxt = cmd_data_in;
                    pulses_nxt = 10'd0;
                    pass_nxt = 1'b0;
                    cnt_nxt = CNT_W'(SETTLE_CYC - 1);
                    case (cmd_op_in)
                        FCS_OP_PROGRAM: begin
                            supply_nxt = 1'b1;
                            state_nxt = S_SETTLE;
                        end
                        FCS_OP_ERASE: begin
                            supply_nxt = 1'b1;
                            addr_nxt = 18'h00000;
                            state_nxt = S_SETTLE;
                        end
                        FCS_OP_SIGNATURE: state_nxt = S_SIG_CMD;
                        FCS_OP_RESET: state_nxt = S_RST1;
                        default: state_nxt = S_RD;
                    endcase
                end
            end
            S_SETTLE: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else begin
                    state_nxt = (op_r == FCS_OP_ERASE) ? S_E_SET : S_P_ARM;
                end
            end
            S_P_ARM: if (bus_done) state_nxt = S_P_DATA;
            S_P_DATA: begin
                if (bus_done) begin
                    pulses_nxt = pulses_r + 10'd1;
                    cnt_nxt = CNT_W'(PULSE_CYCLES - 1);
                    state_nxt = S_P_PULSE;
                end
            end
            S_P_PULSE, S_E_PULSE: begin
                if (cnt_r == '0 || abort_in) begin
                    state_nxt = (state_r == S_P_PULSE) ? S_P_CHECK : S_E_CHECK;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            S_P_CHECK, S_E_CHECK: begin
                if (bus_done) begin
                    cnt_nxt = CNT_W'(WAIT_CYCLES - 1);
                    state_nxt = S_RECOV;
                end
            end
            S_RECOV: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else begin
                    state_nxt = (op_r == FCS_OP_ERASE) ? S_E_READ : S_P_READ;
                end
            end
            S_P_READ: begin
                if (bus_done) begin
                    result_nxt = {8'h00, bus_rdata};
                    if (bus_rdata == data_r) begin
                        pass_nxt = 1'b1;
                        state_nxt = S_RST1;
                    end else if (pulses_r >= PROG_MAX_PULSES) begin
                        state_nxt = S_RST1;
                    end else begin
                        state_nxt = S_P_ARM;
                    end
                end
            end
            S_E_SET: if (bus_done) state_nxt = S_E_GO;
            S_E_GO: begin
                if (bus_done) begin
                    pulses_nxt = pulses_r + 10'd1;
                    cnt_nxt = CNT_W'(PULSE_CYCLES - 1);
                    state_nxt = S_E_PULSE;
                end
            end
            S_E_READ: begin
                if (bus_done) begin
                    result_nxt = {8'h00, bus_rdata};
                    if (bus_rdata == ERASED_BYTE) begin
                        if (addr_r == LAST_ADDR) begin
                            pass_nxt = 1'b1;
                            state_nxt = S_MASK;
                        end else begin
                            addr_nxt = addr_r + 18'h00001;
                            state_nxt = S_E_CHECK;
                        end
                    end else if (pulses_r >= ERASE_MAX_PULSES) begin
                        state_nxt = S_RST1;
                    end else begin
                        state_nxt = S_E_SET;
                    end
                end
            end
            S_MASK: if (bus_done) state_nxt = S_FINISH;
            S_RST1: if (bus_done) state_nxt = S_RST2;
            S_RST2: if (bus_done) state_nxt = S_FINISH;
            S_SIG_CMD: if (bus_done) state_nxt = S_SIG0;
            S_SIG0: begin
                if (bus_done) begin
                    result_nxt[15:8] = bus_rdata;
                    state_nxt = S_SIG1;
                end
            end
            S_SIG1: begin
                if (bus_done) begin
                    result_nxt[7:0] = bus_rdata;
                    pass_nxt = 1'b1;
                    state_nxt = S_RST1;
                end
            end
            S_RD: begin
                if (bus_done) begin
                    result_nxt = {8'h00, bus_rdata};
                    pass_nxt = 1'b1;
                    state_nxt = S_FINISH;
                end
            end
            S_FINISH: begin
                if (op_r == FCS_OP_RESET) begin
                    pass_nxt = 1'b1;
                end
                supply_nxt = 1'b0;
                done_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
        busy_nxt = (state_nxt != S_IDLE);
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= S_IDLE;
            op_r <= FCS_OP_READ;
            cnt_r <= '0;
            pulses_r <= 10'd0;
            addr_r <= 18'h00000;
            data_r <= 8'h00;
            pass_r <= 1'b0;
            result_r <= 16'h0000;
            supply_r <= 1'b0;
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            cnt_r <= cnt_nxt;
            pulses_r <= pulses_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            pass_r <= pass_nxt;
            result_r <= result_nxt;
            supply_r <= supply_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ----
    // Pin cycle engine.
    // ----
    fcs_bus_cycle u_cycle (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .bus(bus.slave),
        .flash_dq_in(flash_dq_in),
        .flash_addr_out(flash_addr_out),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe_out(flash_dq_oe_out),
        .flash_ce_n_out(flash_ce_n_out),
        .flash_oe_n_out(flash_oe_n_out),
        .flash_we_n_out(flash_we_n_out)
    );

    assign busy_out = busy_r;
    assign done_out = done_r;
    assign pass_out = pass_r;
    assign result_out = result_r;
    assign program_supply_out = supply_r;

endmodule : fcs_host

// [tb/fcs_host_props.sv]
`timescale 1ns/100ps
module fcs_host_props
    import fcs_pkg::*;
#(
    parameter int RECOV_CYCLES = RECOV_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic done_out,
    input wire logic pass_out,
    input wire logic program_supply_out,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_oe_n_out,
    input wire logic flash_we_n_out
);
    logic we_q_r;
    logic we_rise;
    logic [7:0] cmd0_r;
    logic [7:0] cmd1_r;
    logic [31:0] since_chk_r;
    logic [31:0] sup_cnt_r;
    logic [9:0] arm_cnt_r;

    assign we_rise = !we_q_r && flash_we_n_out;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            we_q_r <= 1'b1;
            cmd0_r <= 8'hff;
            cmd1_r <= 8'hff;
            since_chk_r <= 32'h7fffffff;
            sup_cnt_r <= 32'h0;
            arm_cnt_r <= 10'h0;
        end else begin
            we_q_r <= flash_we_n_out;
            if (we_rise) begin
                cmd1_r <= cmd0_r;
                cmd0_r <= flash_dq_out;
            end
            if (we_rise && (flash_dq_out == CMD_PROG_CHECK || flash_dq_out == CMD_ERASE_CHECK)) begin
                since_chk_r <= 32'h0;
            end else if (since_chk_r != 32'h7fffffff) begin
                since_chk_r <= since_chk_r + 32'h1;
            end
            sup_cnt_r <= program_supply_out ? sup_cnt_r + 32'h1 : 32'h0;
            if (!program_supply_out) begin
                arm_cnt_r <= 10'h0;
            end else if (we_rise && flash_dq_out == CMD_PROG_ARM) begin
                arm_cnt_r <= arm_cnt_r + 10'h1;
            end
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    property p_verify_wait;
        $fell(flash_oe_n_out) |-> since_chk_r >= VERIFY_CYC;
    endproperty
    a_verify_wait: assert property (p_verify_wait) else $error("read too soon after check");
    property p_recovery;
        $fell(flash_oe_n_out) |-> since_chk_r >= RECOV_CYCLES;
    endproperty
    a_recovery: assert property (p_recovery) else $error("read inside recovery time");
    property p_pulse_limit;
        we_rise && flash_dq_out == CMD_PROG_ARM |-> arm_cnt_r < PROG_MAX_PULSES;
    endproperty
    a_pulse_limit: assert property (p_pulse_limit) else $error("too many program pulses");
    property p_settle;
        we_rise && program_supply_out |-> sup_cnt_r >= SETTLE_CYC;
    endproperty
    a_settle: assert property (p_settle) else $error("command before supply settled");
    property p_erase_check;
        we_rise && cmd1_r == CMD_ERASE && cmd0_r == CMD_ERASE |-> flash_dq_out == CMD_ERASE_CHECK;
    endproperty
    a_erase_check: assert property (p_erase_check) else $error("erase pulse not checked");
    property p_prog_check;
        we_rise && cmd1_r == CMD_PROG_ARM |-> flash_dq_out == CMD_PROG_CHECK;
    endproperty
    a_prog_check: assert property (p_prog_check) else $error("program pulse not checked");
    property p_double_reset;
        done_out |-> (cmd1_r == CMD_RESET && cmd0_r == CMD_RESET) || cmd0_r == CMD_READ;
    endproperty
    a_double_reset: assert property (p_double_reset) else $error("no double reset at end");
    property p_leave_sig;
        we_rise && cmd0_r == CMD_SIGNATURE |-> flash_dq_out == CMD_RESET;
    endproperty
    a_leave_sig: assert property (p_leave_sig) else $error("signature mode not left");

    c_pass: cover property (done_out && pass_out);
    c_fail: cover property (done_out && !pass_out);
    c_verify_read: cover property ($fell(flash_oe_n_out) && program_supply_out);
endmodule : fcs_host_props

bind fcs_host fcs_host_props #(.RECOV_CYCLES(RECOV_CYCLES)) u_fcs_host_props (
    .mclk_in(mclk_in), .rst_in(rst_in), .done_out(done_out), .pass_out(pass_out),
    .program_supply_out(program_supply_out), .flash_dq_out(flash_dq_out),
    .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out)
);

// [tb/fcs_flash_model.sv]
`timescale 1ns/100ps
module fcs_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value.
    parameter logic [7:0] DEV_CODE = 8'hc3, // Arbitrary value.
    parameter realtime CHECK_NS = 6000.0
) (
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic supply_in,
    input wire logic stuck_in,
    input wire logic [17:0] addr_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out
);
    logic [7:0] mem [int];
    logic [7:0] val = 8'h00;
    logic [17:0] a_lat = 18'h0;
    logic [17:0] p_addr = 18'h0;
    int mode = 0;
    int pulses = 0;
    int viol = 0;
    realtime sup_t = 0.0;
    realtime chk_t = 0.0;

    function automatic logic [7:0] rd(input logic [17:0] a);
        rd = mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
    endfunction : rd

    always @(posedge supply_in) sup_t = $realtime;

    always @(negedge we_n_in) begin
        #1;
        if (!ce_n_in && oe_n_in) a_lat = addr_in;
    end

    always @(posedge we_n_in) begin
        if (!ce_n_in && oe_n_in) begin
            if (supply_in && $realtime - sup_t < 100.0) viol++;
            if (mode == 1) begin
                if (supply_in && !stuck_in) mem[int'(a_lat)] = rd(a_lat) & dq_in;
                p_addr = a_lat;
                pulses++;
                mode = 2;
            end else begin
                case (dq_in)
                    8'h40: mode = 1;
                    8'h20: mode = (mode == 4) ? 5 : 4;
                    8'hc0: begin
                        mode = 3;
                        chk_t = $realtime;
                    end
                    8'ha0: begin
                        if (mode == 5 && supply_in && !stuck_in) mem.delete();
                        mode = 6;
                        chk_t = $realtime;
                    end
                    8'h80, 8'h90: mode = 7;
                    default: mode = 0;
                endcase
            end
        end
    end

    always @(negedge oe_n_in) begin
        #1;
        if (mode == 7) val = (addr_in == 18'h0) ? MFR_CODE : DEV_CODE;
        else if (mode == 3) val = rd(p_addr);
        else val = rd(addr_in);
        if ((mode == 3 || mode == 6) && $realtime - chk_t < CHECK_NS) begin
            viol++;
            val = ~val;
        end
    end

    assign dq_out = (!ce_n_in && !oe_n_in) ? val : ~val;
endmodule : fcs_flash_model

// [tb/fcs_host_tb.sv]
`timescale 1ns/100ps
module fcs_host_tb
    import fcs_pkg::*;
;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    fcs_op_type cmd_op_in = FCS_OP_READ;
    logic [17:0] cmd_addr_in = 18'h0;
    logic [7:0] cmd_data_in = 8'h00;
    logic abort_in = 1'b0;
    logic stuck = 1'b0;
    logic busy_out, done_out, pass_out, program_supply_out;
    logic [15:0] result_out;
    logic [17:0] flash_addr_out;
    logic [7:0] flash_dq_out, model_dq, dq_wire;
    logic flash_dq_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
    int err_total = 0;
    int samples_checked = 0;
    int tick = 0;
    int ok_cyc, cyc, p0;
    logic [15:0] fmode;

    assign dq_wire = flash_dq_oe_out ? flash_dq_out : model_dq;
    assign fmode = 16'(u_fcs_flash_model.mode);
    always #2 mclk_in = ~mclk_in;

    fcs_host #(.PULSE_CYCLES(20), .RECOV_CYCLES(10)) u_fcs_host (
        .mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
        .abort_in(abort_in), .busy_out(busy_out), .done_out(done_out),
        .pass_out(pass_out), .result_out(result_out),
        .program_supply_out(program_supply_out), .flash_dq_in(dq_wire),
        .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
        .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out),
        .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out)
    );

    fcs_flash_model u_fcs_flash_model (
        .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
        .supply_in(program_supply_out), .stuck_in(stuck), .addr_in(flash_addr_out),
        .dq_in(dq_wire), .dq_out(model_dq)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic run_cmd(input fcs_op_type op, input logic [17:0] a, input logic [7:0] d,
                           output int n);
        n = 0;
        @(negedge mclk_in);
        cmd_valid_in = 1'b1;
        cmd_op_in = op;
        cmd_addr_in = a;
        cmd_data_in = d;
        @(negedge mclk_in);
        cmd_valid_in = 1'b0;
        while (done_out !== 1'b1 && n < 80000) begin
            @(negedge mclk_in);
            n++;
        end
    endtask : run_cmd

    task automatic t_power_read();
        check("mode", 16'h0, fmode);
        run_cmd(FCS_OP_READ, 18'h00123, 8'h00, cyc);
        check("read", 16'h00ff, {8'h00, result_out[7:0]});
        check("busy", 16'h0, {15'h0, busy_out});
    endtask : t_power_read

    task automatic t_signature();
        run_cmd(FCS_OP_SIGNATURE, 18'h0, 8'h00, cyc);
        check("sig", 16'h5ac3, result_out);
        check("mode", 16'h0, fmode);
    endtask : t_signature

    task automatic t_erase_reset();
        @(negedge mclk_in);
        cmd_valid_in = 1'b1;
        cmd_op_in = FCS_OP_ERASE;
        @(negedge mclk_in);
        cmd_valid_in = 1'b0;
        repeat (300) @(negedge mclk_in);
        check("erase_chk", 16'h6, 16'(u_fcs_flash_model.mode));
        check("supply_on", 16'h1, {15'h0, program_supply_out});
        rst_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        check("supply_rst", 16'h0, {15'h0, program_supply_out});
        rst_in = 1'b0;
        run_cmd(FCS_OP_RESET, 18'h0, 8'h00, cyc);
        check("reset_pass", 16'h1, {15'h0, pass_out});
        check("mode", 16'h0, fmode);
    endtask : t_erase_reset

    task automatic t_program_ok();
        p0 = u_fcs_flash_model.pulses;
        run_cmd(FCS_OP_PROGRAM, LAST_ADDR, 8'h3c, ok_cyc);
        check("prog_pass", 16'h1, {15'h0, pass_out});
        check("pulses", 16'h1, 16'(u_fcs_flash_model.pulses - p0));
        check("supply_off", 16'h0, {15'h0, program_supply_out});
        check("mode", 16'h0, fmode);
        run_cmd(FCS_OP_READ, LAST_ADDR, 8'h00, cyc);
        check("readback", 16'h003c, {8'h00, result_out[7:0]});
    endtask : t_program_ok

    task automatic t_program_abort();
        abort_in = 1'b1;
        run_cmd(FCS_OP_PROGRAM, 18'h00010, 8'h5a, cyc);
        abort_in = 1'b0;
        check("abort_pass", 16'h1, {15'h0, pass_out});
        check("abort_short", 16'h1, {15'h0, cyc < ok_cyc});
    endtask : t_program_abort

    task automatic t_program_fail();
        stuck = 1'b1;
        p0 = u_fcs_flash_model.pulses;
        run_cmd(FCS_OP_PROGRAM, 18'h00007, 8'h00, cyc);
        stuck = 1'b0;
        check("fail_pass", 16'h0, {15'h0, pass_out});
        check("fail_pulses", 16'd25, 16'(u_fcs_flash_model.pulses - p0));
        check("mode", 16'h0, fmode);
    endtask : t_program_fail

    always @(posedge mclk_in) begin
        tick++;
        if (tick == 90000) begin
            err_total++;
            $display("MISMATCH timeout expected done seen hang");
            end_sim();
        end
    end

    initial begin
        repeat (8) @(negedge mclk_in);
        rst_in = 1'b0;
        t_power_read();
        t_signature();
        t_erase_reset();
        t_program_ok();
        t_program_abort();
        t_program_fail();
        check("violations", 16'h0, 16'(u_fcs_flash_model.viol));
        end_sim();
    end
endmodule : fcs_host_tb
